/* File: rtl/lsf_pkg.sv */
// Purpose: constants for the lane status flag block
// Assumes: one 25 MHz clock, synchronous active-low reset
// Notes: register byte address is four times the register index
// Operation
// - transmit FIFO collision sets lane flag bits 15..12 and resets that FIFO
// - code word or disparity error sets lane flag bits 11..8, default zero
// - pattern check ok bits 7..4 default one, drop on checker error
// - a lane status read returns a dropped pattern check ok bit to one
// - signal lost report sets lane flag bits 3..0, default zero
// - collision, decode and signal lost flags clear when read
// - align bit 4 sets on deskew realignment, held until a sync status read
// - receive FIFO collision sets sync bits 3..0 and resets that FIFO
// - sync status bits 15..5 always read zero
// - each lane pin can mirror its signal lost or pattern check ok bit
package lsf_pkg;
   localparam int LANES = 4;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int REG_W = 16;
   // register indices as printed, byte address is index times four
   localparam logic [ADDR_W-1:0] LANE_STATUS_IDX = 8'h16;
   localparam logic [ADDR_W-1:0] LANE_SYNC_STATUS_IDX = 8'h17;
   localparam logic [ADDR_W-1:0] IRQ_STATUS_IDX = 8'h20;
   localparam logic [ADDR_W-1:0] IRQ_CLEAR_IDX = 8'h21;
   localparam logic [ADDR_W-1:0] IRQ_ENABLE_IDX = 8'h22;
   localparam logic [ADDR_W-1:0] PIN_SELECT_IDX = 8'h23;
   // field positions
   localparam int TX_COLL_LSB = 12;
   localparam int DECODE_LSB = 8;
   localparam int PASS_LSB = 4;
   localparam int LOSS_LSB = 0;
   localparam int ALIGN_BIT = 4;
   localparam int RX_COLL_LSB = 0;
   localparam int SEL_W = 2;
   // interrupt status layout
   localparam int IRQ_W = 6;
   localparam int IRQ_TX_COLL = 0;
   localparam int IRQ_DECODE = 1;
   localparam int IRQ_PATTERN = 2;
   localparam int IRQ_LOSS = 3;
   localparam int IRQ_ALIGN = 4;
   localparam int IRQ_RX_COLL = 5;
   // pin source select codes
   localparam logic [SEL_W-1:0] SEL_LEVEL = 2'h0;
   localparam logic [SEL_W-1:0] SEL_COMMA = 2'h1;
   localparam logic [SEL_W-1:0] SEL_LOSS = 2'h2;
   localparam logic [SEL_W-1:0] SEL_PASS = 2'h3;
   // reset values
   localparam logic PASS_RESET = 1'h1;
   localparam logic FLAG_RESET = 1'h0;
   localparam logic LEVEL_PIN_VALUE = 1'h1;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

/* File: rtl/lsf_lane_if.sv */
// Purpose: carries one lane's events, strobes and flags
// Assumes: both ends on clk_in
// Notes: top drives events and strobes, lane drives flags
`timescale 1ns/1ps
`default_nettype none
interface lsf_lane_if;
   logic tx_coll;
   logic rx_coll;
   logic dec_err;
   logic pat_err;
   logic sig_loss;
   logic comma;
   logic rd_status;
   logic rd_sync;
   logic [lsf_pkg::SEL_W-1:0] pin_sel;
   logic tx_coll_flag;
   logic rx_coll_flag;
   logic dec_flag;
   logic pattern_check_ok;
   logic signal_lost;
   logic tx_fifo_rst;
   logic rx_fifo_rst;
   logic multifunction_out_pin;
   modport lane (
      input tx_coll, rx_coll, dec_err, pat_err, sig_loss, comma,
      input rd_status, rd_sync, pin_sel,
      output tx_coll_flag, rx_coll_flag, dec_flag, pattern_check_ok,
      output signal_lost, tx_fifo_rst, rx_fifo_rst, multifunction_out_pin
   );
   modport top (
      output tx_coll, rx_coll, dec_err, pat_err, sig_loss, comma,
      output rd_status, rd_sync, pin_sel,
      input tx_coll_flag, rx_coll_flag, dec_flag, pattern_check_ok,
      input signal_lost, tx_fifo_rst, rx_fifo_rst, multifunction_out_pin
   );
endinterface
`default_nettype wire

/* File: rtl/lsf_lane.sv */
// Purpose: sticky flags, FIFO resets and pin mirror for one lane
// Assumes: rd strobes are one cycle, set on the accepted read
// Notes: events win over clearing reads
`timescale 1ns/1ps
`default_nettype none
module lsf_lane (
   input wire logic clk_in,
   input wire logic rstn_in,
   lsf_lane_if.lane lane
);
   logic tx_reg, tx_next, rx_reg, rx_next, dec_reg, dec_next;
   logic pass_reg, pass_next, loss_reg, loss_next;
   logic txr_reg, txr_next, rxr_reg, rxr_next, pin_reg, pin_next;

   // next flag values, set beats clear
   always_comb
   begin
      tx_next = lane.tx_coll | (tx_reg & ~lane.rd_status);
      dec_next = lane.dec_err | (dec_reg & ~lane.rd_status);
      loss_next = lane.sig_loss | (loss_reg & ~lane.rd_status);
      rx_next = lane.rx_coll | (rx_reg & ~lane.rd_sync);
      if (lane.pat_err)
         pass_next = 1'b0;
      else if (lane.rd_status)
         pass_next = 1'b1;
      else
         pass_next = pass_reg;
      txr_next = lane.tx_coll;
      rxr_next = lane.rx_coll;
      case (lane.pin_sel)
         lsf_pkg::SEL_LEVEL: pin_next = lsf_pkg::LEVEL_PIN_VALUE;
         lsf_pkg::SEL_COMMA: pin_next = lane.comma;
         lsf_pkg::SEL_LOSS: pin_next = loss_reg;
         lsf_pkg::SEL_PASS: pin_next = pass_reg;
         default: pin_next = lsf_pkg::LEVEL_PIN_VALUE;
      endcase
   end

   // flag registers
   always_ff @(posedge clk_in)
   begin
      if (!rstn_in)
      begin
         tx_reg <= lsf_pkg::FLAG_RESET;
         rx_reg <= lsf_pkg::FLAG_RESET;
         dec_reg <= lsf_pkg::FLAG_RESET;
         loss_reg <= lsf_pkg::FLAG_RESET;
         pass_reg <= lsf_pkg::PASS_RESET;
         txr_reg <= lsf_pkg::FLAG_RESET;
         rxr_reg <= lsf_pkg::FLAG_RESET;
         pin_reg <= lsf_pkg::LEVEL_PIN_VALUE;
      end
      else
      begin
         tx_reg <= tx_next;
         rx_reg <= rx_next;
         dec_reg <= dec_next;
         loss_reg <= loss_next;
         pass_reg <= pass_next;
         txr_reg <= txr_next;
         rxr_reg <= rxr_next;
         pin_reg <= pin_next;
      end
   end

   assign lane.tx_coll_flag = tx_reg;
   assign lane.rx_coll_flag = rx_reg;
   assign lane.dec_flag = dec_reg;
   assign lane.pattern_check_ok = pass_reg;
   assign lane.signal_lost = loss_reg;
   assign lane.tx_fifo_rst = txr_reg;
   assign lane.rx_fifo_rst = rxr_reg;
   assign lane.multifunction_out_pin = pin_reg;

   chk_tx_collision: assert property (@(posedge clk_in) disable iff (!rstn_in)
      lane.tx_coll |=> tx_reg && txr_reg) else $error("tx collision not flagged");
   chk_decode_set: assert property (@(posedge clk_in) disable iff (!rstn_in)
      lane.dec_err |=> dec_reg) else $error("decode error not flagged");
   chk_pass_drop: assert property (@(posedge clk_in) disable iff (!rstn_in)
      lane.pat_err |=> !pass_reg) else $error("pass flag did not drop");
   chk_pass_restore: assert property (@(posedge clk_in) disable iff (!rstn_in)
      lane.rd_status && !lane.pat_err |=> pass_reg) else $error("pass not restored");
   chk_loss_set: assert property (@(posedge clk_in) disable iff (!rstn_in)
      lane.sig_loss |=> loss_reg) else $error("signal lost not flagged");
   chk_read_clears: assert property (@(posedge clk_in) disable iff (!rstn_in)
      lane.rd_status && !lane.tx_coll && !lane.dec_err && !lane.sig_loss
      |=> !tx_reg && !dec_reg && !loss_reg) else $error("read did not clear");
   chk_rx_collision: assert property (@(posedge clk_in) disable iff (!rstn_in)
      lane.rx_coll |=> rx_reg ##0 rxr_reg) else $error("rx collision not flagged");
   chk_pin_mirror: assert property (@(posedge clk_in) disable iff (!rstn_in)
      lane.pin_sel == lsf_pkg::SEL_PASS |=> pin_reg == $past(pass_reg))
      else $error("pin does not mirror pass flag");
   chk_event_beats_read: assert property (@(posedge clk_in) disable iff (!rstn_in)
      lane.rd_sync && lane.rx_coll |=> rx_reg) else $error("event lost on read");
   chk_reset_values: assert property (@(posedge clk_in)
      !rstn_in |=> pass_reg && !tx_reg && !dec_reg && !loss_reg && !rx_reg)
      else $error("wrong reset values");
endmodule // lsf_lane
`default_nettype wire

/* File: rtl/lsf_top.sv */
// Purpose: lane status flag registers behind an AHB-Lite slave
// Assumes: single transfers, zero wait states, OKAY response always
// Notes: reads take data and clear flags at the address phase edge
`timescale 1ns/1ps
`default_nettype none
module lsf_top (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   input wire logic [3:0] tx_fifo_collision_in,
   input wire logic [3:0] rx_fifo_collision_in,
   input wire logic [3:0] decode_error_in,
   input wire logic [3:0] pattern_error_in,
   input wire logic [3:0] signal_lost_in,
   input wire logic [3:0] comma_detect_in,
   input wire logic lane_align_in,
   output logic [3:0] tx_fifo_reset_out,
   output logic [3:0] rx_fifo_reset_out,
   output logic [3:0] multifunction_out_pin_out,
   output logic irq_out
);
   localparam int L = lsf_pkg::LANES;
   localparam int SW = lsf_pkg::SEL_W;
   localparam int IW = lsf_pkg::IRQ_W;

   // every check below runs on clk_in and rests during reset
   default clocking @(posedge clk_in);
   endclocking
   default disable iff (!rstn_in);

   // register index from a byte address
   function automatic logic [lsf_pkg::ADDR_W-1:0] reg_idx(input logic [31:0] addr);
      reg_idx = addr[lsf_pkg::ADDR_W+1:2];
   endfunction

   // true when a byte address selects the given register index
   function automatic logic hits(input logic [31:0] addr,
                                 input logic [lsf_pkg::ADDR_W-1:0] idx);
      hits = (addr[31:lsf_pkg::ADDR_W+2] == '0) && (reg_idx(addr) == idx);
   endfunction

   lsf_lane_if lanes [L] ();

   logic [lsf_pkg::REG_W-1:0] status_vec;
   logic [lsf_pkg::REG_W-1:0] sync_vec;
   logic [L-1:0] tx_flags, rx_flags, dec_flags, pass_flags, loss_flags;
   logic [L-1:0] pins, txr, rxr;
   logic accept, rd_accept, rd_status, rd_sync;
   logic align_reg, align_next;
   logic wr_pend_reg, wr_pend_next;
   logic [lsf_pkg::ADDR_W-1:0] wr_idx_reg, wr_idx_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [IW-1:0] irq_stat_reg, irq_stat_next;
   logic [IW-1:0] irq_en_reg, irq_en_next;
   logic [IW-1:0] irq_events, irq_clear;
   logic [L*SW-1:0] pin_sel_reg, pin_sel_next;
   logic irq_reg, irq_next;

   // address phase decode
   assign accept = hsel_in & hready_in & (htrans_in == lsf_pkg::HTRANS_NONSEQ);
   assign rd_accept = accept & ~hwrite_in;
   assign rd_status = rd_accept & hits(haddr_in, lsf_pkg::LANE_STATUS_IDX);
   assign rd_sync = rd_accept & hits(haddr_in, lsf_pkg::LANE_SYNC_STATUS_IDX);

   // one lane block per lane
   genvar g;
   generate
      for (g = 0; g < L; g++)
      begin : g_lane
         assign lanes[g].tx_coll = tx_fifo_collision_in[g];
         assign lanes[g].rx_coll = rx_fifo_collision_in[g];
         assign lanes[g].dec_err = decode_error_in[g];
         assign lanes[g].pat_err = pattern_error_in[g];
         assign lanes[g].sig_loss = signal_lost_in[g];
         assign lanes[g].comma = comma_detect_in[g];
         assign lanes[g].rd_status = rd_status;
         assign lanes[g].rd_sync = rd_sync;
         assign lanes[g].pin_sel = pin_sel_reg[g*SW +: SW];
         assign tx_flags[g] = lanes[g].tx_coll_flag;
         assign rx_flags[g] = lanes[g].rx_coll_flag;
         assign dec_flags[g] = lanes[g].dec_flag;
         assign pass_flags[g] = lanes[g].pattern_check_ok;
         assign loss_flags[g] = lanes[g].signal_lost;
         assign txr[g] = lanes[g].tx_fifo_rst;
         assign rxr[g] = lanes[g].rx_fifo_rst;
         assign pins[g] = lanes[g].multifunction_out_pin;
         lsf_lane u_lane (
            .clk_in(clk_in),
            .rstn_in(rstn_in),
            .lane(lanes[g])
         );
      end
   endgenerate

   // read views of the two status registers
   always_comb
   begin
      status_vec = '0;
      status_vec[lsf_pkg::TX_COLL_LSB +: L] = tx_flags;
      status_vec[lsf_pkg::DECODE_LSB +: L] = dec_flags;
      status_vec[lsf_pkg::PASS_LSB +: L] = pass_flags;
      status_vec[lsf_pkg::LOSS_LSB +: L] = loss_flags;
      sync_vec = '0;
      sync_vec[lsf_pkg::ALIGN_BIT] = align_reg;
      sync_vec[lsf_pkg::RX_COLL_LSB +: L] = rx_flags;
   end

   // interrupt events, one bit per kind, all lanes merged
   always_comb
   begin
      irq_events = '0;
      irq_events[lsf_pkg::IRQ_TX_COLL] = |tx_fifo_collision_in;
      irq_events[lsf_pkg::IRQ_DECODE] = |decode_error_in;
      irq_events[lsf_pkg::IRQ_PATTERN] = |pattern_error_in;
      irq_events[lsf_pkg::IRQ_LOSS] = |signal_lost_in;
      irq_events[lsf_pkg::IRQ_ALIGN] = lane_align_in;
      irq_events[lsf_pkg::IRQ_RX_COLL] = |rx_fifo_collision_in;
   end

   // next value of the align flag, set beats the clearing read
   always_comb
   begin
      align_next = lane_align_in | (align_reg & ~rd_sync);
   end

   // align flag register
   always_ff @(posedge clk_in)
   begin
      if (!rstn_in)
      begin
         align_reg <= lsf_pkg::FLAG_RESET;
      end
      else
      begin
         align_reg <= align_next;
      end
   end

   // next bus state; the status registers have no write path
   always_comb
   begin
      wr_pend_next = accept & hwrite_in;
      wr_idx_next = accept ? reg_idx(haddr_in) : wr_idx_reg;
      rdata_next = rdata_reg;
      // read data captured at the address phase edge
      if (rd_accept)
      begin
         rdata_next = '0;
         if (hits(haddr_in, lsf_pkg::LANE_STATUS_IDX))
            rdata_next[lsf_pkg::REG_W-1:0] = status_vec;
         else if (hits(haddr_in, lsf_pkg::LANE_SYNC_STATUS_IDX))
            rdata_next[lsf_pkg::REG_W-1:0] = sync_vec;
         else if (hits(haddr_in, lsf_pkg::IRQ_STATUS_IDX))
            rdata_next[IW-1:0] = irq_stat_reg;
         else if (hits(haddr_in, lsf_pkg::IRQ_ENABLE_IDX))
            rdata_next[IW-1:0] = irq_en_reg;
         else if (hits(haddr_in, lsf_pkg::PIN_SELECT_IDX))
            rdata_next[L*SW-1:0] = pin_sel_reg;
      end
   end

   // bus state registers
   always_ff @(posedge clk_in)
   begin
      if (!rstn_in)
      begin
         wr_pend_reg <= lsf_pkg::FLAG_RESET;
         wr_idx_reg <= '0;
         rdata_reg <= '0;
      end
      else
      begin
         wr_pend_reg <= wr_pend_next;
         wr_idx_reg <= wr_idx_next;
         rdata_reg <= rdata_next;
      end
   end

   // next interrupt state, set beats clear
   always_comb
   begin
      irq_en_next = irq_en_reg;
      irq_clear = '0;
      if (wr_pend_reg && (wr_idx_reg == lsf_pkg::IRQ_CLEAR_IDX))
         irq_clear = hwdata_in[IW-1:0];
      if (wr_pend_reg && (wr_idx_reg == lsf_pkg::IRQ_ENABLE_IDX))
         irq_en_next = hwdata_in[IW-1:0];
      irq_stat_next = irq_events | (irq_stat_reg & ~irq_clear);
      irq_next = |(irq_stat_next & irq_en_next);
   end

   // interrupt registers
   always_ff @(posedge clk_in)
   begin
      if (!rstn_in)
      begin
         irq_stat_reg <= '0;
         irq_en_reg <= '0;
         irq_reg <= lsf_pkg::FLAG_RESET;
      end
      else
      begin
         irq_stat_reg <= irq_stat_next;
         irq_en_reg <= irq_en_next;
         irq_reg <= irq_next;
      end
   end

   // next lane pin source select
   always_comb
   begin
      pin_sel_next = pin_sel_reg;
      if (wr_pend_reg && (wr_idx_reg == lsf_pkg::PIN_SELECT_IDX))
         pin_sel_next = hwdata_in[L*SW-1:0];
   end

   // pin source select register
   always_ff @(posedge clk_in)
   begin
      if (!rstn_in)
      begin
         pin_sel_reg <= '0;
      end
      else
      begin
         pin_sel_reg <= pin_sel_next;
      end
   end

   // outputs
   assign hrdata_out = rdata_reg;
   assign hreadyout_out = 1'b1;
   assign hresp_out = 1'b0;
   assign tx_fifo_reset_out = txr;
   assign rx_fifo_reset_out = rxr;
   assign multifunction_out_pin_out = pins;
   assign irq_out = irq_reg;

   chk_align_set: assert property (@(posedge clk_in) disable iff (!rstn_in)
      lane_align_in |=> align_reg) else $error("align flag not set");
   chk_align_clear: assert property (@(posedge clk_in) disable iff (!rstn_in)
      rd_sync && !lane_align_in |=> !align_reg) else $error("align flag not cleared");
   chk_sync_reserved: assert property (@(posedge clk_in) disable iff (!rstn_in)
      rd_sync |=> hrdata_out[lsf_pkg::DATA_W-1:lsf_pkg::ALIGN_BIT+1] == '0)
      else $error("reserved bits nonzero");
   chk_status_readback: assert property (@(posedge clk_in) disable iff (!rstn_in)
      rd_status |=> hrdata_out[lsf_pkg::REG_W-1:0] == $past(status_vec))
      else $error("bad status data");
   chk_write_ignored: assert property (@(posedge clk_in) disable iff (!rstn_in)
      wr_pend_reg && wr_idx_reg == lsf_pkg::LANE_STATUS_IDX && !rd_status
      && irq_events == '0 |=> pass_flags == $past(pass_flags)
      && tx_flags == $past(tx_flags)) else $error("write changed a status flag");
   chk_irq_level: assert property (@(posedge clk_in) disable iff (!rstn_in)
      irq_out == |(irq_stat_reg & irq_en_reg)) else $error("irq level mismatch");

   // fifo resets and read data
   chk_tx_fifo_reset: assert property (
      tx_fifo_reset_out == $past(tx_fifo_collision_in))
      else $error("tx fifo reset mismatch");
   chk_rx_fifo_reset: assert property (
      rx_fifo_reset_out == $past(rx_fifo_collision_in))
      else $error("rx fifo reset mismatch");
   chk_read_upper_zero: assert property (
      rd_accept |=> hrdata_out[lsf_pkg::DATA_W-1:lsf_pkg::REG_W] == '0)
      else $error("upper read bits nonzero");
   chk_read_holds: assert property (
      !rd_accept |=> $stable(hrdata_out))
      else $error("read data changed without a read");

   // clearing reads and sticky flags
   chk_status_clear_read: assert property (
      rd_status |=> tx_flags == $past(tx_fifo_collision_in)
      && dec_flags == $past(decode_error_in)
      && loss_flags == $past(signal_lost_in))
      else $error("status flags wrong after read");
   chk_pass_after_read: assert property (
      rd_status |=> pass_flags == ~$past(pattern_error_in))
      else $error("pass flags wrong after read");
   chk_sync_clear_read: assert property (
      rd_sync |=> rx_flags == $past(rx_fifo_collision_in)
      && align_reg == $past(lane_align_in))
      else $error("sync flags wrong after read");
   chk_flags_sticky: assert property (
      !rd_status |=> (tx_flags & $past(tx_flags)) == $past(tx_flags)
      && (dec_flags & $past(dec_flags)) == $past(dec_flags)
      && (loss_flags & $past(loss_flags)) == $past(loss_flags))
      else $error("status flag lost without a read");
   chk_pass_stays_low: assert property (
      !rd_status |=> (pass_flags & ~$past(pass_flags)) == '0)
      else $error("pass flag rose without a read");
   chk_align_sticky: assert property (
      align_reg && !rd_sync |=> align_reg)
      else $error("align flag lost without a read");
   chk_rx_sticky: assert property (
      !rd_sync |=> (rx_flags & $past(rx_flags)) == $past(rx_flags))
      else $error("rx collision flag lost");
   chk_sync_write_ignored: assert property (
      wr_pend_reg && wr_idx_reg == lsf_pkg::LANE_SYNC_STATUS_IDX && !rd_sync
      && irq_events == '0 |=> rx_flags == $past(rx_flags) && align_reg == $past(align_reg))
      else $error("write changed a sync flag");

   // interrupt status
   chk_irq_set: assert property (
      irq_events != '0 |=> (irq_stat_reg & $past(irq_events)) == $past(irq_events))
      else $error("interrupt event not latched");
   chk_irq_clear: assert property (
      irq_events == '0 |=> irq_stat_reg == ($past(irq_stat_reg) & ~$past(irq_clear)))
      else $error("interrupt clear wrong");
endmodule // lsf_top
`default_nettype wire

/* File: verif/tb.sv */
// Purpose: self-checking bench for the lane status flag registers
// Assumes: zero wait-state slave, events sampled at each rising edge
// Notes: a bus-watching model predicts every read, pin, fifo reset and irq level
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk_in = 1'h0;
   logic rstn_in = 1'h0;
   logic hsel_in = 1'h0;
   logic [31:0] haddr_in = 32'h0;
   logic [1:0] htrans_in = 2'h0;
   logic hwrite_in = 1'h0;
   logic [2:0] hsize_in = 3'h2;
   logic [31:0] hwdata_in = 32'h0;
   logic [31:0] hrdata_out;
   logic hreadyout_out;
   logic hresp_out;
   logic [3:0] tx_in = 4'h0;
   logic [3:0] rx_in = 4'h0;
   logic [3:0] dec_in = 4'h0;
   logic [3:0] pat_in = 4'h0;
   logic [3:0] los_in = 4'h0;
   logic [3:0] comma_in = 4'h0;
   logic al_in = 1'h0;
   logic [3:0] txr_out;
   logic [3:0] rxr_out;
   logic [3:0] pin_out;
   logic irq_out;
   int failures = 0;
   int n_checks = 0;
   int seed = 32'h2e9d;
   // model state
   logic [15:0] m_st;
   logic [4:0] m_sy;
   logic [5:0] m_irq;
   logic [5:0] m_en;
   logic [7:0] m_psel;
   logic [31:0] m_rd;
   logic [31:0] m_wa;
   logic m_wp;
   logic acc;
   logic rs;
   logic rsy;
   logic [3:0] e_tx;
   logic [3:0] e_rx;

   lsf_top DUT (.clk_in(clk_in), .rstn_in(rstn_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
      .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in),
      .hwdata_in(hwdata_in), .hready_in(hreadyout_out), .hrdata_out(hrdata_out),
      .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .tx_fifo_collision_in(tx_in),
      .rx_fifo_collision_in(rx_in), .decode_error_in(dec_in), .pattern_error_in(pat_in),
      .signal_lost_in(los_in), .comma_detect_in(comma_in), .lane_align_in(al_in),
      .tx_fifo_reset_out(txr_out), .rx_fifo_reset_out(rxr_out),
      .multifunction_out_pin_out(pin_out), .irq_out(irq_out));

   // 25 MHz clock
   always #20 clk_in = ~clk_in;

   // behavioural model, watches the same inputs at the same edges
   always @(posedge clk_in)
   begin
      if (!rstn_in)
      begin
         m_st = 16'h00f0;
         m_sy = 5'h00;
         m_irq = 6'h00;
         m_en = 6'h00;
         m_psel = 8'h00;
         m_wp = 1'h0;
      end
      else
      begin
         if (m_wp && m_wa == 32'h84)
            m_irq = m_irq & ~hwdata_in[5:0];
         if (m_wp && m_wa == 32'h88)
            m_en = hwdata_in[5:0];
         if (m_wp && m_wa == 32'h8c)
            m_psel = hwdata_in[7:0];
         acc = hsel_in && htrans_in == 2'h2 && hreadyout_out;
         rs = acc && !hwrite_in && haddr_in == 32'h58;
         rsy = acc && !hwrite_in && haddr_in == 32'h5c;
         if (acc && !hwrite_in)
            case (haddr_in)
               32'h58: m_rd = {16'h0, m_st};
               32'h5c: m_rd = {27'h0, m_sy};
               32'h80: m_rd = {26'h0, m_irq};
               32'h88: m_rd = {26'h0, m_en};
               32'h8c: m_rd = {24'h0, m_psel};
               default: m_rd = 32'h0;
            endcase
         m_wp = acc && hwrite_in;
         m_wa = haddr_in;
         m_st[15:12] = tx_in | (rs ? 4'h0 : m_st[15:12]);
         m_st[11:8] = dec_in | (rs ? 4'h0 : m_st[11:8]);
         m_st[7:4] = (m_st[7:4] | {4{rs}}) & ~pat_in;
         m_st[3:0] = los_in | (rs ? 4'h0 : m_st[3:0]);
         m_sy[4] = al_in | (!rsy && m_sy[4]);
         m_sy[3:0] = rx_in | (rsy ? 4'h0 : m_sy[3:0]);
         m_irq = m_irq | {|rx_in, al_in, |los_in, |pat_in, |dec_in, |tx_in};
      end
   end

   // fifo resets and irq level, looked at once each edge has landed
   always @(posedge clk_in)
   begin
      e_tx = tx_in;
      e_rx = rx_in;
      #1;
      if (rstn_in)
      begin
         chk("tx_fifo_reset", {28'h0, e_tx}, {28'h0, txr_out});
         chk("rx_fifo_reset", {28'h0, e_rx}, {28'h0, rxr_out});
         chk("irq", {31'h0, |(m_irq & m_en)}, {31'h0, irq_out});
         chk("hresp", 32'h0, {31'h0, hresp_out});
         chk("hreadyout", 32'h1, {31'h0, hreadyout_out});
      end
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // bounded wait for the slave's ready
   task automatic wait_rdy;
      int n;
      n = 0;
      do
      begin
         @(posedge clk_in);
         n++;
      end
      while (hreadyout_out !== 1'h1 && n < 20);
      if (hreadyout_out !== 1'h1)
      begin
         failures++;
         $display("Error hreadyout expected 1 seen timeout");
         close_out();
      end
   endtask

   task automatic ev(input logic [3:0] t, r, d, p, l, input logic a);
      tx_in <= t;
      rx_in <= r;
      dec_in <= d;
      pat_in <= p;
      los_in <= l;
      al_in <= a;
   endtask

   // one single transfer; events given with the address phase end with it
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      hsel_in <= 1'h1;
      haddr_in <= a;
      htrans_in <= 2'h2;
      hwrite_in <= wr;
      hsize_in <= 3'h2;
      wait_rdy();
      hsel_in <= 1'h0;
      htrans_in <= 2'h0;
      hwdata_in <= d;
      ev(4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 1'h0);
      wait_rdy();
      q = hrdata_out;
   endtask

   task automatic rd(input logic [31:0] a);
      logic [31:0] q;
      bus(1'h0, a, 32'h0, q);
      chk("rdata", m_rd, q);
   endtask

   task automatic pins;
      logic [3:0] e;
      for (int i = 0; i < 4; i++)
         case (m_psel[2*i +: 2])
            lsf_pkg::SEL_LEVEL: e[i] = 1'h1;
            lsf_pkg::SEL_COMMA: e[i] = comma_in[i];
            lsf_pkg::SEL_LOSS: e[i] = m_st[i];
            default: e[i] = m_st[4+i];
         endcase
      chk("pin", {28'h0, e}, {28'h0, pin_out});
   endtask

   initial
   begin
      logic [31:0] q;
      logic [31:0] r;
      repeat (10) @(posedge clk_in);
      rstn_in <= 1'h1;
      @(posedge clk_in);
      bus(1'h0, 32'h58, 32'h0, q);
      chk("lane_status", 32'h000000f0, q);
      bus(1'h0, 32'h5c, 32'h0, q);
      chk("lane_sync_status", 32'h0, q);
      $display("test reset defaults done");
      // unmapped place, then writes aimed at the read-only flags
      bus(1'h1, 32'h60, 32'hffffffff, q);
      rd(32'h60);
      ev(4'h5, 4'h3, 4'h9, 4'h2, 4'h6, 1'h1);
      @(posedge clk_in);
      ev(4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 1'h0);
      bus(1'h1, 32'h58, 32'h0000ff0f, q);
      bus(1'h1, 32'h5c, 32'h0000ffe0, q);
      rd(32'h58);
      rd(32'h5c);
      $display("test read-only and unmapped done");
      bus(1'h1, 32'h88, 32'h0000003f, q);
      rd(32'h88);
      // random events, many landing on the clearing read itself
      for (int i = 0; i < 150; i++)
      begin
         r = $random(seed);
         ev(r[3:0] & r[7:4], r[7:4] & r[11:8], r[11:8] & r[15:12], r[15:12] & r[19:16],
            r[19:16] & r[23:20], &r[25:24]);
         comma_in <= r[31:28];
         if (r[26] && r[29])
            bus(1'h1, 32'h58, r, q);
         else
            rd(r[27] ? 32'h58 : 32'h5c);
      end
      $display("test random events done");
      // pin mirror for each select code
      ev(4'h0, 4'h0, 4'h0, 4'h3, 4'h5, 1'h0);
      comma_in <= 4'ha;
      @(posedge clk_in);
      ev(4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 1'h0);
      for (int i = 0; i < 4; i++)
      begin
         bus(1'h1, 32'h8c, {24'h0, {4{i[1:0]}}}, q);
         repeat (3) @(posedge clk_in);
         pins();
      end
      $display("test pin select done");
      // interrupt clear, mask and raise again
      rd(32'h80);
      bus(1'h1, 32'h84, 32'h0000003f, q);
      rd(32'h80);
      bus(1'h1, 32'h88, 32'h0, q);
      ev(4'h1, 4'h2, 4'h0, 4'h0, 4'h0, 1'h1);
      @(posedge clk_in);
      ev(4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 1'h0);
      rd(32'h80);
      bus(1'h1, 32'h88, 32'h00000031, q);
      repeat (2) @(posedge clk_in);
      bus(1'h1, 32'h84, 32'h0000003f, q);
      rd(32'h80);
      $display("test interrupts done");
      close_out();
   end
endmodule // tb
`default_nettype wire
